/* File: hdl/lcdc_pkg.sv */
package lcdc_pkg;

////////////////////////////////////////////////////////////////////////////////
// Timing
localparam int unsigned CLK_PERIOD_NS = 10;
localparam int unsigned BLINK_PERIOD_MS = 1000;
// Half of the blink period in system clocks
localparam int unsigned BLINK_HALF_CYC =
	(BLINK_PERIOD_MS * 1000000 / 2) / CLK_PERIOD_NS;
localparam int unsigned BLINK_CNT_W = 26;

////////////////////////////////////////////////////////////////////////////////
// Instruction encodings
localparam logic [1:0] RS_INSTR = 2'b10;
localparam logic [2:0] OP_FRAME = 3'b100;
localparam logic [4:0] OP_DISP_CTL = 5'b00100;
localparam logic [5:0] OP_SHIFT = 6'b000100;
localparam logic [6:0] OP_SCREEN = 7'b0000001;
localparam logic [5:0] OP_DISP_CFG = 6'b000001;
localparam int unsigned DC_D_BIT = 2;
localparam int unsigned DC_C_BIT = 1;
localparam int unsigned DC_B_BIT = 0;
localparam int unsigned SH_SC_BIT = 1;
localparam int unsigned SH_RL_BIT = 0;
localparam int unsigned SCR_L_BIT = 0;
localparam int unsigned CFG_P_BIT = 1;
localparam int unsigned CFG_Q_BIT = 0;

////////////////////////////////////////////////////////////////////////////////
// Frame rate, reset values
localparam logic [4:0] FF_RESET = 5'h07;
localparam logic [4:0] FF_TOP_FIRST = 5'h15;
localparam logic [18:0] CLK_HZ_RESET = 19'd64000;
localparam logic [8:0] FRAME_HZ_RESET = 9'd80;

////////////////////////////////////////////////////////////////////////////////
// Geometry
localparam logic [6:0] ONE_LINE_LAST = 7'd39;
localparam logic [6:0] TWO_LINE_LAST = 7'd79;
localparam logic [5:0] OFS_LAST = 6'd39;
localparam logic [6:0] COL_LAST = 7'd99;
localparam logic [7:0] PAIR_BASE = 8'd100;
localparam logic [7:0] PAIR_LAST = 8'd199;
localparam logic [4:0] TEXT_ROW_LAST = 5'd15;
localparam logic [4:0] ICON_ROW_A = 5'd16;
localparam logic [4:0] ICON_ROW_B = 5'd17;
localparam logic [4:0] SL_ROWS = 5'd8;
localparam logic [4:0] CURSOR_DOTS = 5'h1f;

////////////////////////////////////////////////////////////////////////////////
// Register map
localparam logic [3:0] REG_CTRL = 4'h0;
localparam logic [3:0] REG_STATUS = 4'h4;
localparam logic [3:0] REG_ADDR = 4'h8;
localparam logic [3:0] REG_FREQ = 4'hc;
localparam int unsigned CTRL_EXT_BIT = 0;
localparam int unsigned CTRL_TWO_BIT = 1;
localparam int unsigned CTRL_SL_BIT = 2;

////////////////////////////////////////////////////////////////////////////////
// Types
typedef struct packed {
	logic [1:0] rs;
	logic rw;
	logic [7:0] data;
} lcdc_cmd_t;

typedef struct packed {
	logic [8:0] frame_hz;
	logic [18:0] clk_hz;
} lcdc_freq_t;

typedef struct packed {
	logic [6:0] phys_col;
	logic [7:0] pair_col;
	logic [4:0] phys_row;
} lcdc_map_t;

typedef enum logic [1:0] {
	SH_IDLE = 2'b00,
	SH_PEND = 2'b01
} lcdc_shift_st_t;

typedef struct packed {
	logic [4:0] frame_code;
	logic disp_on;
	logic cursor_on;
	logic blink_on;
	logic split_mirror;
	logic col_mirror;
	logic row_mirror;
	logic ext_clk;
	logic two_line;
	logic single_line;
	lcdc_shift_st_t sh_st;
	logic sh_sc;
	logic sh_rl;
	logic [6:0] ac;
	logic [5:0] offset;
	logic [BLINK_CNT_W-1:0] blink_cnt;
	logic blink_phase;
	logic [18:0] clk_hz;
	logic [8:0] frame_hz;
	logic blank;
	logic [4:0] cursor_dots;
	logic char_all_on;
	lcdc_map_t map;
	logic [31:0] rdata;
} lcdc_state_t;

localparam lcdc_state_t ST_RESET = '{
	frame_code: FF_RESET,
	clk_hz: CLK_HZ_RESET,
	frame_hz: FRAME_HZ_RESET,
	blank: 1'b1,
	sh_st: SH_IDLE,
	default: '0
};

// Frame and clock frequency for each rate code
function automatic lcdc_freq_t lcdc_freq_lookup(input logic [4:0] code);
	lcdc_freq_t f;
	case (code)
		5'h00: f = '{9'd45, 19'd36000};
		5'h01: f = '{9'd50, 19'd39724};
		5'h02: f = '{9'd55, 19'd44308};
		5'h03: f = '{9'd60, 19'd48000};
		5'h04: f = '{9'd65, 19'd52364};
		5'h05: f = '{9'd70, 19'd54857};
		5'h06: f = '{9'd75, 19'd60632};
		5'h07: f = '{9'd80, 19'd64000};
		5'h08: f = '{9'd85, 19'd67765};
		5'h09: f = '{9'd90, 19'd72000};
		5'h0a: f = '{9'd95, 19'd76800};
		5'h0b: f = '{9'd100, 19'd82286};
		5'h0c: f = '{9'd110, 19'd88615};
		5'h0d: f = '{9'd120, 19'd96000};
		5'h0e: f = '{9'd130, 19'd104727};
		5'h0f: f = '{9'd145, 19'd115200};
		5'h10: f = '{9'd160, 19'd128000};
		5'h11: f = '{9'd180, 19'd144000};
		5'h12: f = '{9'd210, 19'd164571};
		5'h13: f = '{9'd240, 19'd192000};
		5'h14: f = '{9'd290, 19'd230400};
		default: f = '{9'd360, 19'd288000};
	endcase
	return f;
endfunction

endpackage

/* File: hdl/lcdc_scan_map.sv */
`timescale 1ns/1ps
`default_nettype none

// Maps a scan position to the driven column, its split partner and the row
module lcdc_scan_map
	import lcdc_pkg::*;
(
	input wire logic [6:0] scan_col_i,
	input wire logic [4:0] scan_row_i,
	input wire logic col_mirror_i,
	input wire logic row_mirror_i,
	input wire logic split_mirror_i,
	input wire logic single_line_mux_i,
	output lcdc_map_t map_o
);

////////////////////////////////////////////////////////////////////////////////
// Column order and split pairing
always_comb
begin
	map_o.phys_col = col_mirror_i ? (COL_LAST - scan_col_i) : scan_col_i;
	map_o.pair_col = PAIR_BASE + {1'b0, map_o.phys_col};
	if (split_mirror_i)
		map_o.pair_col = PAIR_LAST - {1'b0, map_o.phys_col};
	map_o.phys_row = scan_row_i;
	if (single_line_mux_i)
	begin
		if (scan_row_i < SL_ROWS)
			map_o.phys_row = row_mirror_i ? (TEXT_ROW_LAST - scan_row_i)
				: scan_row_i;
		else
			map_o.phys_row = row_mirror_i ? ICON_ROW_B : ICON_ROW_A;
	end
	else if (row_mirror_i)
	begin
		if (scan_row_i == ICON_ROW_A)
			map_o.phys_row = ICON_ROW_B;
		else if (scan_row_i == ICON_ROW_B)
			map_o.phys_row = ICON_ROW_A;
		else
			map_o.phys_row = TEXT_ROW_LAST - scan_row_i;
	end
end

endmodule
`default_nettype wire

/* File: hdl/lcdc_cmd_core.sv */
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Rate code picks frame and clock frequency
// - Reset rate is the 80 Hz setting
// - Rate code acts only on internal clock
// - Display control sets display, cursor, blink
// - Display off blanks, keeps stored text
// - Cursor is five dots, eighth line
// - Blink alternates all-on, one second period
// - Shift instruction picks shift/move and direction
// - Two-line cursor passes position 40 onward
// - Display shift moves lines together, offset wraps 39/0
// - Display shift keeps counter; move steps it
// - Standard split pairing 0/100 to 99/199
// - Mirrored split pairing 0/199 to 99/100
// - Column mirror outputs 99 down to 0
// - Row mirror reverses text and icon rows
// - Single line uses 0-7/16 or 15-8/17
// - Both mirrors rotate 180, reset zero
module lcdc_cmd_core
	import lcdc_pkg::*;
#(
	parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic cmd_valid_i,
	input wire lcdc_cmd_t cmd_i,
	input wire logic [6:0] scan_col_i,
	input wire logic [4:0] scan_row_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic [4:0] frame_rate_code_o,
	output logic [18:0] clk_freq_hz_o,
	output logic [8:0] frame_freq_hz_o,
	output logic panel_blank_o,
	output logic [4:0] cursor_dots_o,
	output logic char_all_on_o,
	output logic [6:0] addr_cnt_o,
	output logic [5:0] disp_offset_o,
	output logic [6:0] phys_col_o,
	output logic [7:0] pair_col_o,
	output logic [4:0] phys_row_o
);

localparam logic [BLINK_CNT_W-1:0] BLINK_END =
	BLINK_CNT_W'(BLINK_HALF - 1);

lcdc_state_t st_r;
lcdc_state_t st_nxt;
lcdc_map_t map_w;
lcdc_freq_t fq_w;
logic instr;
logic is_frame;
logic is_dctl;
logic is_shift;
logic is_screen;
logic is_dcfg;
logic complete;
logic [6:0] ac_last;

////////////////////////////////////////////////////////////////////////////////
// Instruction decode
// fixed-bit decode
assign instr = cmd_valid_i && !cmd_i.rw && (cmd_i.rs == RS_INSTR);
assign is_frame = instr && (cmd_i.data[7:5] == OP_FRAME);
assign is_dctl = instr && (cmd_i.data[7:3] == OP_DISP_CTL);
assign is_shift = instr && (cmd_i.data[7:2] == OP_SHIFT);
assign is_screen = instr && (cmd_i.data[7:1] == OP_SCREEN);
assign is_dcfg = instr && (cmd_i.data[7:2] == OP_DISP_CFG);
assign complete = cmd_valid_i && (st_r.sh_st == SH_PEND);
assign ac_last = st_r.two_line ? TWO_LINE_LAST : ONE_LINE_LAST;
assign fq_w = lcdc_freq_lookup(st_r.frame_code);

lcdc_scan_map u_map (
	.scan_col_i(scan_col_i),
	.scan_row_i(scan_row_i),
	.col_mirror_i(st_r.col_mirror),
	.row_mirror_i(st_r.row_mirror),
	.split_mirror_i(st_r.split_mirror),
	.single_line_mux_i(st_r.single_line),
	.map_o(map_w)
);

////////////////////////////////////////////////////////////////////////////////
// Next state
always_comb
begin
	st_nxt = st_r;
	if (is_frame)
		st_nxt.frame_code = cmd_i.data[4:0];
	if (is_dctl)
	begin
		st_nxt.disp_on = cmd_i.data[DC_D_BIT];
		st_nxt.cursor_on = cmd_i.data[DC_C_BIT];
		st_nxt.blink_on = cmd_i.data[DC_B_BIT];
	end
	if (is_screen)
		st_nxt.split_mirror = cmd_i.data[SCR_L_BIT];
	if (is_dcfg)
	begin
		st_nxt.col_mirror = cmd_i.data[CFG_P_BIT];
		st_nxt.row_mirror = cmd_i.data[CFG_Q_BIT];
	end
	// Finish a pending shift before a new one is queued
	if (complete)
	begin
		st_nxt.sh_st = SH_IDLE;
		if (st_r.sh_sc)
		begin
			if (st_r.sh_rl)
				st_nxt.offset = (st_r.offset == OFS_LAST) ? '0
					: st_r.offset + 6'd1;
			else
				st_nxt.offset = (st_r.offset == '0) ? OFS_LAST
					: st_r.offset - 6'd1;
		end
		else
		begin
			// two-line mode: position 40 runs on to next line
			if (st_r.sh_rl)
				st_nxt.ac = (st_r.ac >= ac_last) ? '0 : st_r.ac + 7'd1;
			else
				st_nxt.ac = (st_r.ac == '0) ? ac_last : st_r.ac - 7'd1;
		end
	end
	if (is_shift)
	begin
		st_nxt.sh_st = SH_PEND;
		st_nxt.sh_sc = cmd_i.data[SH_SC_BIT];
		st_nxt.sh_rl = cmd_i.data[SH_RL_BIT];
	end
	if (st_r.blink_on)
	begin
		if (st_r.blink_cnt == BLINK_END)
		begin
			st_nxt.blink_cnt = '0;
			st_nxt.blink_phase = !st_r.blink_phase;
		end
		else
			st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
	end
	else
	begin
		st_nxt.blink_cnt = '0;
		st_nxt.blink_phase = 1'b0;
	end
	st_nxt.clk_hz = st_r.ext_clk ? '0 : fq_w.clk_hz;
	st_nxt.frame_hz = st_r.ext_clk ? '0 : fq_w.frame_hz;
	st_nxt.blank = !st_r.disp_on;
	st_nxt.cursor_dots = (st_r.cursor_on && st_r.disp_on) ? CURSOR_DOTS
		: '0;
	st_nxt.char_all_on = st_r.blink_on && st_r.blink_phase && st_r.disp_on;
	st_nxt.map = map_w;
	// Control register write
	if (reg_wr_i && (reg_addr_i == REG_CTRL))
	begin
		st_nxt.ext_clk = reg_wdata_i[CTRL_EXT_BIT];
		st_nxt.two_line = reg_wdata_i[CTRL_TWO_BIT];
		st_nxt.single_line = reg_wdata_i[CTRL_SL_BIT];
	end
	// Read data stand for one cycle only
	st_nxt.rdata = '0;
	if (reg_rd_i)
	begin
		case (reg_addr_i)
			REG_CTRL: st_nxt.rdata = {29'h0, st_r.single_line,
				st_r.two_line, st_r.ext_clk};
			REG_STATUS: st_nxt.rdata = {19'h0, st_r.blink_phase,
				(st_r.sh_st == SH_PEND), st_r.frame_code,
				st_r.row_mirror, st_r.col_mirror, st_r.split_mirror,
				st_r.disp_on, st_r.cursor_on, st_r.blink_on};
			REG_ADDR: st_nxt.rdata = {18'h0, st_r.offset, 1'b0, st_r.ac};
			REG_FREQ: st_nxt.rdata = {3'h0, st_r.frame_hz, 1'b0,
				st_r.clk_hz};
			default: st_nxt.rdata = '0;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// State register
// reset to 80 Hz code
always_ff @(posedge clk_sys_i or negedge rst_b_i)
begin
	if (!rst_b_i)
		st_r <= ST_RESET;
	else
		st_r <= st_nxt;
end

// Outputs straight from the state register
assign reg_rdata_o = st_r.rdata;
assign frame_rate_code_o = st_r.frame_code;
assign clk_freq_hz_o = st_r.clk_hz;
assign frame_freq_hz_o = st_r.frame_hz;
assign panel_blank_o = st_r.blank;
assign cursor_dots_o = st_r.cursor_dots;
assign char_all_on_o = st_r.char_all_on;
assign addr_cnt_o = st_r.ac;
assign disp_offset_o = st_r.offset;
assign phys_col_o = st_r.map.phys_col;
assign pair_col_o = st_r.map.pair_col;
assign phys_row_o = st_r.map.phys_row;

////////////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_b_i);

rate_reset_a: assert property (
	$past(rst_b_i) == 1'b0 |-> st_r.frame_code == FF_RESET)
	else $error("rate code not at 80 Hz after reset");
rate_table_a: assert property (
	(st_r.frame_code >= FF_TOP_FIRST) && !st_r.ext_clk && !is_frame
	|=> clk_freq_hz_o == 19'd288000 && frame_freq_hz_o == 9'd360)
	else $error("top rate codes not 360 Hz");
ext_clock_a: assert property (
	st_r.ext_clk |=> clk_freq_hz_o == '0)
	else $error("rate code acting on external clock");
disp_ctl_a: assert property (
	is_dctl |=> {st_r.disp_on, st_r.cursor_on, st_r.blink_on}
		== $past(cmd_i.data[2:0]))
	else $error("display control bits not taken");
blank_on_a: assert property (
	is_dctl && !cmd_i.data[DC_D_BIT] |=> ##1 panel_blank_o)
	else $error("panel not blanked");
cursor_dots_a: assert property (
	st_r.cursor_on && st_r.disp_on |=> cursor_dots_o == CURSOR_DOTS)
	else $error("cursor dots missing");
blink_toggle_a: assert property (
	$changed(st_r.blink_phase) && st_r.blink_on
	|-> $past(st_r.blink_cnt) == BLINK_END)
	else $error("blink phase toggled off schedule");
shift_queue_a: assert property (
	is_shift |=> st_r.sh_st == SH_PEND
		&& st_r.sh_sc == $past(cmd_i.data[SH_SC_BIT]))
	else $error("shift not queued");
line_wrap_a: assert property (
	complete && !st_r.sh_sc && st_r.sh_rl && st_r.two_line
	&& st_r.ac == ONE_LINE_LAST |=> addr_cnt_o == 7'd40)
	else $error("cursor did not pass to next line");
shift_keep_a: assert property (
	complete && st_r.sh_sc |=> $stable(st_r.ac))
	else $error("display shift moved counter");
offset_step_a: assert property (
	complete && st_r.sh_sc && st_r.sh_rl && st_r.offset == OFS_LAST
	|=> disp_offset_o == '0)
	else $error("display offset out of line range");
split_pair_a: assert property (
	st_r.split_mirror && !is_screen && !is_dcfg && scan_col_i == '0
	&& !st_r.col_mirror |=> pair_col_o == PAIR_LAST)
	else $error("mirrored pairing wrong");
col_mirror_a: assert property (
	st_r.col_mirror && scan_col_i == '0 |=> phys_col_o == COL_LAST)
	else $error("column mirror wrong");
sl_rows_a: assert property (
	st_r.single_line && st_r.row_mirror && scan_row_i == SL_ROWS
	|=> phys_row_o == ICON_ROW_B)
	else $error("single line icon row wrong");
rotate_a: assert property (
	st_r.col_mirror && st_r.row_mirror && !st_r.single_line
	&& scan_col_i == '0 && scan_row_i == '0
	|=> phys_col_o == COL_LAST && phys_row_o == TEXT_ROW_LAST)
	else $error("rotation corner wrong");
split_std_a: assert property (
	!st_r.split_mirror && !st_r.col_mirror && scan_col_i == '0
	|=> pair_col_o == PAIR_BASE)
	else $error("standard pairing wrong");
row_mirror_a: assert property (
	st_r.row_mirror && !st_r.single_line && scan_row_i == ICON_ROW_A
	|=> phys_row_o == ICON_ROW_B)
	else $error("icon rows not swapped");
display_on_a: assert property (
	st_r.disp_on |=> !panel_blank_o)
	else $error("panel blank while display on");
char_blink_a: assert property (
	st_r.blink_on && st_r.blink_phase && st_r.disp_on |=> char_all_on_o)
	else $error("blink character not all on");
move_left_a: assert property (
	complete && !st_r.sh_sc && !st_r.sh_rl && st_r.ac != '0
	|=> addr_cnt_o == $past(st_r.ac) - 7'd1)
	else $error("cursor move left did not step");

rate_cmd_c: cover property (is_frame ##1 !st_r.ext_clk);
shift_done_c: cover property (is_shift ##[1:4] complete);
blink_run_c: cover property (st_r.blink_on && st_r.blink_phase);
rotate_c: cover property (st_r.col_mirror && st_r.row_mirror);

endmodule
`default_nettype wire

/* File: hdl/lcdc_dummy_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verif/lcdc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side: frames instruction bytes and closes each shift with an update
module lcdc_host_model
	import lcdc_pkg::*;
#(
	parameter int unsigned GAP = 4
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic req_i,
	input wire logic [7:0] byte_i,
	output logic cmd_valid_o,
	output lcdc_cmd_t cmd_o
);
logic [2:0] gap_r;

always_ff @(posedge clk_sys_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		cmd_valid_o <= 1'b0;
		cmd_o <= '0;
		gap_r <= 3'h0;
	end
	else if (req_i)
	begin
		cmd_valid_o <= 1'b1;
		cmd_o <= '{RS_INSTR, 1'b0, byte_i};
		if (byte_i[7:2] == OP_SHIFT)
			gap_r <= 3'(GAP);
	end
	else if (gap_r == 3'h1)
	begin
		cmd_valid_o <= 1'b1;
		cmd_o <= '{2'h3, 1'b0, 8'h00}; // Update byte, not decoded here
		gap_r <= 3'h0;
	end
	else
	begin
		cmd_valid_o <= 1'b0;
		cmd_o <= ~cmd_o; // Idle bus inverts the last byte every cycle
		if (gap_r != 3'h0)
			gap_r <= gap_r - 3'h1;
	end
end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top
	import lcdc_pkg::*;
;
localparam int unsigned BH = 8;
logic clk_sys_i = 1'b0, rst_b_i = 1'b0, req = 1'b0, cmd_valid_i;
logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, panel_blank_o, char_all_on_o;
logic [7:0] byt = 8'h00, pair_col_o;
lcdc_cmd_t cmd_i;
logic [6:0] scan_col_i = 7'h00, addr_cnt_o, phys_col_o;
logic [4:0] scan_row_i = 5'h00, frame_rate_code_o, cursor_dots_o, phys_row_o;
logic [3:0] reg_addr_i = 4'h0;
logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
logic [18:0] clk_freq_hz_o;
logic [8:0] frame_freq_hz_o;
logic [5:0] disp_offset_o;
int bad_count = 0, n_compared = 0;
logic [8:0] fr_tab [22] = '{9'h2d, 9'h32, 9'h37, 9'h3c, 9'h41, 9'h46, 9'h4b,
	9'h50, 9'h55, 9'h5a, 9'h5f, 9'h64, 9'h6e, 9'h78, 9'h82, 9'h91, 9'ha0,
	9'hb4, 9'hd2, 9'hf0, 9'h122, 9'h168};
logic [18:0] ck_tab [22] = '{19'h8ca0, 19'h9b2c, 19'had14, 19'hbb80,
	19'hcc8c, 19'hd649, 19'hecd8, 19'hfa00, 19'h108b5, 19'h11940, 19'h12c00,
	19'h1416e, 19'h15a27, 19'h17700, 19'h19917, 19'h1c200, 19'h1f400,
	19'h23280, 19'h282db, 19'h2ee00, 19'h38400, 19'h46500};

// System clock
always #5 clk_sys_i = ~clk_sys_i;

lcdc_host_model lcdc_host_model_inst (.clk_sys_i, .rst_b_i, .req_i(req),
	.byte_i(byt), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
lcdc_cmd_core #(.BLINK_HALF(BH)) lcdc_cmd_core_inst (.clk_sys_i, .rst_b_i,
	.cmd_valid_i, .cmd_i, .scan_col_i, .scan_row_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frame_rate_code_o,
	.clk_freq_hz_o, .frame_freq_hz_o, .panel_blank_o, .cursor_dots_o,
	.char_all_on_o, .addr_cnt_o, .disp_offset_o, .phys_col_o, .pair_col_o,
	.phys_row_o);

////////////////////////////////////////////////////////////////////////////
// Bus tasks
task automatic tick(input int n);
	repeat (n) @(posedge clk_sys_i);
	#1;
endtask

task automatic send(input logic [7:0] b);
	@(posedge clk_sys_i);
	req <= 1'b1;
	byt <= b;
	@(posedge clk_sys_i);
	req <= 1'b0;
endtask

task automatic wreg(input logic [3:0] a, input logic [31:0] v);
	@(posedge clk_sys_i);
	reg_wr_i <= 1'b1;
	reg_addr_i <= a;
	reg_wdata_i <= v;
	@(posedge clk_sys_i);
	reg_wr_i <= 1'b0;
endtask

task automatic rreg(input logic [3:0] a);
	@(posedge clk_sys_i);
	reg_rd_i <= 1'b1;
	reg_addr_i <= a;
	@(posedge clk_sys_i);
	reg_rd_i <= 1'b0;
	#1 d = reg_rdata_o;
endtask

// Expected driven row for a scan row
function automatic logic [4:0] exp_row(int r, logic q, logic sl);
	if (r > (sl ? 7 : 15))
		return q ? (sl ? ICON_ROW_B : 5'(33 - r)) : (sl ? ICON_ROW_A : 5'(r));
	return q ? 5'(15 - r) : 5'(r);
endfunction

// Sweep columns and rows under one mirror setting
task automatic map_check(input logic p, q, l, sl);
	logic [7:0] pc;
	send({6'h01, p, q});
	send({7'h01, l});
	wreg(REG_CTRL, {29'h0, sl, 2'h2});
	tick(4);
	for (int c = 0; c < 100; c++)
	begin
		@(posedge clk_sys_i);
		scan_col_i <= 7'(c);
		tick(2);
		`CHK(phys_col_o, p ? COL_LAST - 7'(c) : 7'(c)) // Column order
		pc = 8'(p ? 99 - c : c);
		`CHK(pair_col_o, l ? PAIR_LAST - pc : PAIR_BASE + pc)
	end
	for (int r = 0; r < (sl ? 9 : 18); r++)
	begin
		@(posedge clk_sys_i);
		scan_row_i <= 5'(r);
		tick(2);
		`CHK(phys_row_o, exp_row(r, q, sl)) // Row order
	end
endtask

task automatic final_report;
	$display("compared %0d mismatches %0d", n_compared, bad_count);
	if (bad_count == 0 && n_compared > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask

// Watchdog
initial
begin
	#500000;
	bad_count++;
	final_report();
end

// Main sequence
initial
begin
	int k, n;
	repeat (8) @(posedge clk_sys_i);
	rst_b_i <= 1'b1;
	tick(2);
	`CHK(frame_rate_code_o, 5'h07) // Reset rate
	`CHK(panel_blank_o, 1'b1) // Display off
	rreg(REG_STATUS);
	`CHK(d, 32'h1c0) // Flags and mirrors clear
	rreg(REG_FREQ);
	`CHK(d, 32'h0500fa00) // Reset frequencies
	tick(1);
	`CHK(reg_rdata_o, 32'h0) // Read data gone
	wreg(REG_STATUS, 32'hffffffff);
	rreg(REG_STATUS);
	`CHK(d, 32'h1c0) // Read-only status
	rreg(4'h2);
	`CHK(d, 32'h0) // Unmapped reads zero
	for (int i = 0; i < 32; i++)
	begin
		k = (i > 21) ? 21 : i;
		send(8'h80 | 8'(i));
		tick(4);
		`CHK(frame_rate_code_o, 5'(i)) // Stored code
		`CHK(clk_freq_hz_o, ck_tab[k]) // Clock rate
		`CHK(frame_freq_hz_o, fr_tab[k]) // Frame rate
	end
	wreg(REG_CTRL, 32'h1);
	tick(3);
	`CHK(clk_freq_hz_o, 19'h0) // External clock
	`CHK(frame_rate_code_o, 5'h1f) // Code kept
	wreg(REG_CTRL, 32'h0);
	send(8'h87);
	tick(4);
	`CHK(clk_freq_hz_o, 19'hfa00) // Internal again
	for (int i = 0; i < 8; i++)
	begin
		send(8'h20 | 8'(i));
		tick(4);
		rreg(REG_STATUS);
		`CHK(d[2:0], 3'(i)) // Enable bits
		`CHK(panel_blank_o, ~i[2]) // Blanking
		`CHK(cursor_dots_o, (i[2] && i[1]) ? CURSOR_DOTS : 5'h00)
	end
	n = 0;
	while (char_all_on_o !== 1'b1 && n < 40)
	begin
		tick(1);
		n++;
	end
	n = 0;
	while (char_all_on_o === 1'b1 && n < 40)
	begin
		tick(1);
		n++;
	end
	`CHK(n, BH) // Half blink period
	wreg(REG_CTRL, 32'h2);
	rreg(REG_CTRL);
	`CHK(d, 32'h2) // Two-line readback
	for (int i = 1; i <= 40; i++)
	begin
		send(8'h11);
		if (i == 1)
		begin
			rreg(REG_STATUS);
			`CHK(d[11], 1'b1) // Shift pending
		end
		tick(8);
		`CHK(addr_cnt_o, 7'(i)) // Past position 40
	end
	send(8'h10);
	tick(8);
	`CHK(addr_cnt_o, 7'h27) // Move left steps
	send(8'h13);
	tick(8);
	`CHK(addr_cnt_o, 7'h27) // Shift keeps counter
	`CHK(disp_offset_o, 6'h01) // Common offset moved
	rreg(REG_ADDR);
	`CHK(d, 32'h127) // Offset and counter
	send(8'h12);
	tick(8);
	`CHK(disp_offset_o, 6'h0) // Shift back
	for (int m = 0; m < 16; m++)
		map_check(m[3], m[2], m[1], m[0]);
	final_report();
end
endmodule
`default_nettype wire
